// ### hdl/qrv_pkg.sv
`default_nettype none
package qrv_pkg;
   // Clock period in picoseconds (200 MHz).
   localparam int CLK_PERIOD_PS = 5000;
   // Frequency limits in kHz for the two variants.
   localparam int FREQ_LIM_LOW_KHZ = 136;
   localparam int FREQ_LIM_HIGH_KHZ = 225;
   // Starter and fallback frequencies in kHz; plain defaults.
   localparam int STARTER_FREQ_KHZ = 22;
   localparam int FALLBACK_FREQ_KHZ = 13;
   // Blanking times in nanoseconds.
   localparam int BLANK_SHORT_NS = 2500;
   localparam int BLANK_LONG_NS = 6300;
   // Strobe delay after turn-off and turn-on delay, in nanoseconds.
   localparam int STROBE_NS = 1000;
   localparam int TRIG_DELAY_NS = 100;
   // Propagation delay of the current turn-off, in nanoseconds.
   localparam int PROP_DELAY_NS = 50;
   // Minimum on-time pulse width for every turn-on, in nanoseconds.
   localparam int MIN_ON_NS = 300;
   // Width of the cycle counters.
   localparam int CNT_W = 16;

   // Longest times round down, least times round up.
   function automatic int khz_to_cycles(input int khz);
      return 1000000000 / (khz * CLK_PERIOD_PS);
   endfunction
   function automatic int ns_to_cycles_up(input int ns);
      return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   endfunction

   localparam logic [CNT_W-1:0] LIM_LOW_CYC = CNT_W'(khz_to_cycles(FREQ_LIM_LOW_KHZ));
   localparam logic [CNT_W-1:0] LIM_HIGH_CYC = CNT_W'(khz_to_cycles(FREQ_LIM_HIGH_KHZ));
   localparam logic [CNT_W-1:0] STARTER_CYC = CNT_W'(khz_to_cycles(STARTER_FREQ_KHZ));
   localparam logic [CNT_W-1:0] FALLBACK_CYC = CNT_W'(khz_to_cycles(FALLBACK_FREQ_KHZ));
   localparam logic [CNT_W-1:0] BLANK_SHORT_CYC = CNT_W'(ns_to_cycles_up(BLANK_SHORT_NS));
   localparam logic [CNT_W-1:0] BLANK_LONG_CYC = CNT_W'(ns_to_cycles_up(BLANK_LONG_NS));
   localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(ns_to_cycles_up(STROBE_NS));
   localparam logic [CNT_W-1:0] TRIG_DELAY_CYC = CNT_W'(ns_to_cycles_up(TRIG_DELAY_NS));
   localparam logic [CNT_W-1:0] PROP_DELAY_CYC = CNT_W'(ns_to_cycles_up(PROP_DELAY_NS));
   localparam logic [CNT_W-1:0] MIN_ON_CYC = CNT_W'(ns_to_cycles_up(MIN_ON_NS));
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   // Raw comparator results from the analog front end.
   typedef struct packed {
      logic arm_cmp;   // Sense input above arm threshold.
      logic trig_cmp;  // Sense input below trigger threshold.
      logic level_cmp; // Sense input above the 1 V selection level.
      logic ilim_cmp;  // Drain current at or above its limit.
   } qrv_cmp_type;

   // Comparator levels of a quiet sense input: below trigger, not armed.
   // Resetting to these keeps a false edge from following reset.
   localparam qrv_cmp_type CMP_IDLE = '{arm_cmp: 1'b0, trig_cmp: 1'b1, level_cmp: 1'b0,
      ilim_cmp: 1'b0};

   // Switch controller states.
   typedef enum logic [1:0] {QRV_OFF, QRV_DELAY, QRV_ON, QRV_TURNOFF} qrv_state_type;
endpackage
`default_nettype wire

// ### hdl/qrv_sync.sv
`default_nettype none
// Two-flop synchroniser for a group of comparator levels.
module qrv_sync #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // First stage; read only by the second stage.
   logic [WIDTH-1:0] meta_r;

   // Both stages start at the idle levels, so no edge is seen after reset.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta_r <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ### hdl/qrv_turn_on_ctrl.sv
`default_nettype none
// Turn-on timing of a valley-skipping quasi-resonant controller.
module qrv_turn_on_ctrl
   import qrv_pkg::*;
#(
   parameter bit HIGH_VARIANT = 1'b0
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire qrv_pkg::qrv_cmp_type cmp_in,
   output logic gate_on,
   output logic long_blank,
   output logic starter_mode,
   output logic fallback_mode
);
   import qrv_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers and edge detection.

   qrv_cmp_type cmp_s;         // Synchronised comparators.
   qrv_cmp_type cmp_d_r;       // Previous synchronised value.
   wire logic [3:0] cmp_s_bits;

   qrv_sync #(.WIDTH(4), .RST_VAL(CMP_IDLE)) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in(cmp_in),
      .sync_out(cmp_s_bits)
   );
   assign cmp_s = cmp_s_bits;

   // Arming only on a rising crossing, trigger only on a falling one.
   wire logic arm_rise = cmp_s.arm_cmp & ~cmp_d_r.arm_cmp;
   wire logic trig_fall = cmp_s.trig_cmp & ~cmp_d_r.trig_cmp;

   ////////////////////////////////////////////////////////////////////////////
   // Timers and state.

   qrv_state_type state_r, state_nxt;
   logic [CNT_W-1:0] osc_r;      // Cycles since last turn-on.
   logic [CNT_W-1:0] off_r;      // Cycles since last turn-off.
   logic [CNT_W-1:0] dly_r;      // Delay counter for turn-on and turn-off.
   logic armed_r;                // Trigger armed by a rising crossing.
   logic ever_armed_r;           // Arming seen in this period.
   logic high_all_r;             // Arm comparator high for the whole period.
   logic long_blank_r;           // Blanking selection.
   logic starter_mode_r; // Latest turn-on came from the starter.

   // Oscillator period is chosen at build time by the variant.
   wire logic [CNT_W-1:0] osc_lim = HIGH_VARIANT ? LIM_HIGH_CYC : LIM_LOW_CYC;
   wire logic [CNT_W-1:0] blank_cyc = long_blank_r ? BLANK_LONG_CYC : BLANK_SHORT_CYC;
   wire logic osc_done = osc_r >= osc_lim;
   // Blanking can stretch the inhibit beyond the oscillator period.
   wire logic blank_done = off_r >= blank_cyc;
   wire logic turn_on_ok = osc_done & blank_done;
   // Starter when this period has not armed; fallback when the level stayed
   // high, since a pin stuck high never arms and the starter would run too fast.
   wire logic starter = ~ever_armed_r;
   wire logic stuck_high = high_all_r;
   wire logic starter_due = starter & ~stuck_high;
   wire logic starter_fire = starter_due & (osc_r >= STARTER_CYC) & blank_done;
   wire logic fallback_fire = stuck_high & (osc_r >= FALLBACK_CYC) & blank_done;
   // A falling edge counts only when armed and the window is open.
   wire logic valley_fire = armed_r & trig_fall & turn_on_ok;
   wire logic strobe_now = (state_r == QRV_OFF) && (off_r == STROBE_CYC);
   wire logic min_on_done = osc_r >= MIN_ON_CYC;

   // Next state: off, waiting the trigger delay, on, propagation delay.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         QRV_OFF: begin
            if (valley_fire || starter_fire || fallback_fire) begin
               state_nxt = QRV_DELAY;
            end
         end
         QRV_DELAY: begin
            if (dly_r >= TRIG_DELAY_CYC) begin
               state_nxt = QRV_ON;
            end
         end
         QRV_ON: begin
            // Current limit compares against the ceiling set in the analog
            // path by sunk sense current; here only its crossing is seen.
            if (cmp_s.ilim_cmp && min_on_done) begin
               state_nxt = QRV_TURNOFF;
            end
         end
         QRV_TURNOFF: begin
            if (dly_r >= PROP_DELAY_CYC) begin
               state_nxt = QRV_OFF;
            end
         end
         default: state_nxt = QRV_OFF;
      endcase
   end

   // State and delay counter.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= QRV_OFF;
         dly_r <= CNT_ZERO;
         cmp_d_r <= CMP_IDLE;
      end else begin
         state_r <= state_nxt;
         dly_r <= (state_nxt != state_r) ? CNT_ZERO : dly_r + CNT_ONE;
         cmp_d_r <= cmp_s;
      end
   end

   // Oscillator restarts at each turn-on and saturates at its top.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         osc_r <= CNT_ZERO;
      end else if (state_r == QRV_DELAY && state_nxt == QRV_ON) begin
         osc_r <= CNT_ZERO;
      end else if (osc_r != '1) begin
         osc_r <= osc_r + CNT_ONE;
      end
   end

   // Off-time counter, cleared at turn-off, saturating.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         off_r <= BLANK_LONG_CYC;
      end else if (state_r != QRV_OFF) begin
         off_r <= CNT_ZERO;
      end else if (off_r != '1) begin
         off_r <= off_r + CNT_ONE;
      end
   end

   // Arming: set by a rising crossing after blanking, cleared by any
   // falling edge so an ignored valley needs a fresh rising edge.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         armed_r <= 1'b0;
      end else if (state_r != QRV_OFF) begin
         armed_r <= 1'b0;
      end else if (arm_rise && blank_done) begin
         armed_r <= 1'b1;
      end else if (trig_fall) begin
         armed_r <= 1'b0;
      end
   end

   // Per-period arming history and stuck-high detection.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ever_armed_r <= 1'b0;
         high_all_r <= 1'b0;
      end else if (state_r == QRV_DELAY && state_nxt == QRV_ON) begin
         // Every period must arm afresh, or the starter takes over again.
         ever_armed_r <= 1'b0;
         high_all_r <= cmp_s.arm_cmp;
      end else begin
         if (arm_rise && blank_done) begin
            ever_armed_r <= 1'b1;
         end
         if (!cmp_s.arm_cmp) begin
            high_all_r <= 1'b0;
         end
      end
   end

   // Blanking selection sampled at the strobe; low level picks long.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         long_blank_r <= 1'b1;
      end else if (strobe_now) begin
         long_blank_r <= ~cmp_s.level_cmp;
      end
   end

   // Mode shown outside: whether the latest turn-on came from the starter.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         starter_mode_r <= 1'b1;
      end else if (state_r == QRV_OFF && state_nxt == QRV_DELAY) begin
         starter_mode_r <= starter_fire;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs.

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         gate_on <= 1'b0;
         long_blank <= 1'b1;
         starter_mode <= 1'b1;
         fallback_mode <= 1'b0;
      end else begin
         // The gate holds through the propagation delay, so blanking and the
         // strobe count from the real turn-off.
         gate_on <= (state_nxt == QRV_ON) || (state_nxt == QRV_TURNOFF);
         long_blank <= long_blank_r;
         starter_mode <= starter_mode_r;
         fallback_mode <= stuck_high;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   sequence turn_on_seq;
      (state_r == QRV_OFF) ##1 (state_r == QRV_DELAY);
   endsequence

   osc_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(gate_on) |-> osc_r <= CNT_ONE)
      else $error("oscillator not restarted at turn-on");
   early_ignore_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_r == QRV_OFF && trig_fall && !osc_done && !starter_fire && !fallback_fire)
      |=> state_r == QRV_OFF)
      else $error("early falling edge turned switch on");
   late_fire_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_r == QRV_OFF && armed_r && trig_fall && turn_on_ok) |=> state_r == QRV_DELAY)
      else $error("valid valley did not start turn-on");
   blank_inhibit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      turn_on_seq |-> $past(off_r) >= $past(blank_cyc))
      else $error("turn-on inside blanking");
   blank_select_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      strobe_now |=> long_blank_r == !$past(cmp_s.level_cmp))
      else $error("wrong blanking selection");
   on_delay_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      turn_on_seq |-> ##[1:40] gate_on)
      else $error("turn-on delay too long");
   ilim_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_r == QRV_ON && cmp_s.ilim_cmp && min_on_done) |-> ##[1:20] !gate_on)
      else $error("current limit did not turn off");
   starter_rate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_r == QRV_OFF && starter && osc_r < STARTER_CYC && !valley_fire)
      |=> state_r == QRV_OFF)
      else $error("starter fired too early");
   fallback_rate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (state_r == QRV_OFF && stuck_high && osc_r < FALLBACK_CYC && !valley_fire)
      |=> state_r == QRV_OFF)
      else $error("fallback fired too early");
endmodule
`default_nettype wire

// ### testbench/qrv_far_side.sv
`default_nettype none
// Power switch and auxiliary winding as the comparators see them.
module qrv_far_side (
   input wire logic ref_clk,
   input wire logic gate_on,
   input wire logic ring_en,
   input wire logic lvl_hi,
   input wire logic stuck_hi,
   input wire logic [15:0] on_len,
   output var qrv_pkg::qrv_cmp_type cmp_out
);
   import qrv_pkg::*;
   // Valley spacing in cycles; the swing sits above arm level for half of it.
   localparam int RING_CYC = 100;
   logic [15:0] t_r; // Cycles since the gate last changed.
   logic gate_d_r; // Gate level one cycle ago.
   logic up; // Winding swing above the arm level.
   // A winding too weak to reach the arm level never swings, as at power-up.
   // A pin stuck above the arm level holds the swing high, even while on.
   assign up = (ring_en && !gate_on && (32'(t_r) % RING_CYC) < RING_CYC / 2) || stuck_hi;
   // Time is counted from each gate change so ringing starts at turn-off.
   always_ff @(posedge ref_clk) begin
      gate_d_r <= gate_on;
      t_r <= (gate_on != gate_d_r) ? 16'h0000 : t_r + 16'h0001;
   end
   assign cmp_out.arm_cmp = up;
   assign cmp_out.trig_cmp = !up;
   // The plateau after turn-off follows the output voltage and outlasts the strobe.
   assign cmp_out.level_cmp = lvl_hi && !gate_on;
   // The current ramps while on; its limit is reached after on_len cycles.
   assign cmp_out.ilim_cmp = gate_on && (t_r >= on_len);
endmodule
`default_nettype wire

// ### testbench/qrv_turn_on_ctrl_tb_top.sv
`default_nettype none
module qrv_turn_on_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import qrv_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ring_en = 1'b0; // Winding strong enough to arm.
   logic lvl_hi = 1'b1; // Sense above 1 V at the strobe.
   logic stuck_hi = 1'b0; // Sense pin held above the arm level.
   logic [15:0] on_len = 16'h0050;
   qrv_cmp_type cmp;
   logic gate_on;
   logic long_blank;
   logic starter_mode;
   logic fallback_mode;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [31:0] lfsr = 32'hd254;
   int n_on;
   int n_off;
   logic lo_ok;

   qrv_turn_on_ctrl u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmp_in(cmp),
      .gate_on(gate_on), .long_blank(long_blank), .starter_mode(starter_mode),
      .fallback_mode(fallback_mode));
   qrv_far_side u_far (.ref_clk(ref_clk), .gate_on(gate_on), .ring_en(ring_en),
      .lvl_hi(lvl_hi), .stuck_hi(stuck_hi), .on_len(on_len), .cmp_out(cmp));

   ////////////////////////////////////////////////////////////////////////////////
   // The clock toggles every half period of 5 ns.
   always #2.5 ref_clk = ~ref_clk;

   // Hang guard; the run needs two starter periods, a fallback and ten valleys.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next value of the stimulus shift register.
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Compares and counts; case inequality so an unknown never matches.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Counts edges until the gate shows val, sampling after each edge settles.
   task automatic wait_gate(input logic val, output int n);
      n = 0;
      while (gate_on !== val && n < 50000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 50000) begin
         err_total++;
         give_verdict();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, starter, valley-locked operation, then a stuck-high sense pin.
   initial begin
      repeat (20) @(posedge ref_clk);
      #1;
      check(gate_on, 1'b0);
      check(long_blank, 1'b1);
      check(starter_mode, 1'b1);
      check(fallback_mode, 1'b0);
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      $display("test reset done");
      // Without arming the switch still starts, once per starter period.
      wait_gate(1'b1, n_on);
      check(32'(n_on <= int'(STARTER_CYC) + 40), 32'h1);
      check(starter_mode, 1'b1);
      @(posedge ref_clk);
      ring_en <= 1'b1;
      $display("test starter done");
      for (int i = 0; i < 10; i++) begin
         wait_gate(1'b0, n_on);
         // The gate never drops before the shorter of on_len and the minimum on-time.
         lo_ok = n_on >= int'(on_len) || n_on >= int'(MIN_ON_CYC);
         check(lo_ok, 1'b1);
         check(32'(n_on <= int'(on_len) + 8 + int'(PROP_DELAY_CYC) || on_len < MIN_ON_CYC),
            32'h1);
         wait_gate(1'b1, n_off);
         // Early valleys are skipped; the next one after the period is taken.
         check(32'(n_on + n_off >= int'(LIM_LOW_CYC)), 32'h1);
         check(32'(n_on + n_off <= int'(LIM_LOW_CYC) + 230), 32'h1);
         check(long_blank, !lvl_hi);
         check(starter_mode, 1'b0);
         check(fallback_mode, 1'b0);
         // Corner on-times first: below the minimum, then the longest.
         lfsr = lfsr_next(lfsr);
         @(posedge ref_clk);
         lvl_hi <= lfsr[7];
         on_len <= (i == 0) ? 16'h0014 : (i == 1) ? 16'h00c8 : 16'(60 + lfsr[15:8] % 141);
      end
      $display("test valley operation done");
      // A pin stuck high never arms: one starter turn-on, then the fallback rate.
      stuck_hi <= 1'b1;
      wait_gate(1'b0, n_on);
      wait_gate(1'b1, n_off);
      check(32'(n_on + n_off >= int'(STARTER_CYC)), 32'h1);
      check(32'(n_on + n_off <= int'(STARTER_CYC) + 40), 32'h1);
      check(starter_mode, 1'b1);
      wait_gate(1'b0, n_on);
      wait_gate(1'b1, n_off);
      check(32'(n_on + n_off >= int'(FALLBACK_CYC)), 32'h1);
      check(32'(n_on + n_off <= int'(FALLBACK_CYC) + 40), 32'h1);
      check(fallback_mode, 1'b1);
      check(starter_mode, 1'b0);
      $display("test stuck sense done");
      give_verdict();
   end
endmodule
`default_nettype wire
